// File: design/sci_status_control_mute_wakeup.sv
`include "sci_params.svh"
module sci_status_control_mute_wakeup
	import sci_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output wire logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output wire logic        wready,
	output wire logic [1:0]  bresp,
	output wire logic        bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output wire logic        arready,
	output wire logic [31:0] rdata,
	output wire logic [1:0]  rresp,
	output wire logic        rvalid,
	input  wire logic        rready,
	input  wire logic        halt_mode,
	input  wire logic        cpu_irq_mask,
	input  wire logic        rx_pin,
	output wire logic        tx_pin,
	output wire logic        tx_pin_oe,
	output wire logic        irq,
	output wire logic        wait_exit
);
	// One-hot register select: ctrl2, ctrl1, baud, data, status.
	function automatic logic [4:0] reg_sel(input logic [7:0] a);
		return {a == `OFF_CTRL2, a == `OFF_CTRL1, a == `OFF_BAUD,
			a == `OFF_DATA, a == `OFF_STATUS};
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic       aw_held_r, w_held_r, bvalid_r, rvalid_r, wstrb_r;
	logic [7:0] waddr_r, wbyte_r, rdata_r;
	logic [1:0] bresp_r, rresp_r;
	logic [7:0] status_r, arm_r, ctrl1_r, ctrl2_r, baud_r, baud_cnt_r;
	logic [7:0] tx_hold_r, rx_hold_r;
	logic       hold_full_r, pre_pend_r, brk_pend_r, txon_q_r, brk_q_r, idle_arm_r;
	logic [7:0] status_nxt, arm_nxt, ctrl2_nxt, set_v, clr_v, txrx_clr_v;

	wire logic       run     = !halt_mode;
	wire logic       wr_fire = aw_held_r && w_held_r && !bvalid_r;
	wire logic [4:0] wr_sel  = reg_sel(waddr_r);
	wire logic       rd_fire = arvalid && !rvalid_r;
	wire logic [4:0] rd_sel  = reg_sel(araddr);
	// Writes with byte lane 0 disabled change nothing; the registers sit there.
	wire logic       wr_en   = wr_fire && wstrb_r && run;
	wire logic       wr_c1   = wr_en && wr_sel[3];
	wire logic       wr_c2   = wr_en && wr_sel[4];
	wire logic       st_acc  = run && ((rd_fire && rd_sel[0]) || (wr_en && wr_sel[0]));
	wire logic       dr_rd   = run && rd_fire && rd_sel[1];
	wire logic       dr_wr   = wr_en && wr_sel[1];

	wire logic tx_empty_irq_en    = ctrl2_r[`C2_TIE];
	wire logic tx_done_irq_en   = ctrl2_r[`C2_TX_DONE_IRQ_EN];
	wire logic rx_irq_en    = ctrl2_r[`C2_RIE];
	wire logic line_quiet_irq_en   = ctrl2_r[`C2_LINE_QUIET_IRQ_EN];
	wire logic tx_on  = ctrl2_r[`C2_TXON];
	wire logic rx_on  = ctrl2_r[`C2_RXON];
	wire logic mute   = ctrl2_r[`C2_MUTE];
	wire logic brk    = ctrl2_r[`C2_BRK];
	wire logic nine   = ctrl1_r[`C1_NINE];
	wire logic wake_m = ctrl1_r[`C1_WAKE];

	wire logic [7:0] rd_mux =
		({8{rd_sel[0]}} & {status_r[7:1], 1'b0}) |
		({8{rd_sel[1]}} & rx_hold_r) |
		({8{rd_sel[2]}} & baud_r) |
		({8{rd_sel[3]}} & ctrl1_r) |
		({8{rd_sel[4]}} & ctrl2_r);

	assign awready = !aw_held_r && !bvalid_r;
	assign wready  = !w_held_r && !bvalid_r;
	assign arready = !rvalid_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign rvalid  = rvalid_r;
	assign rresp   = rresp_r;
	assign rdata   = {24'h00_0000, rdata_r};

	////////////////////////////////////////////////////////////////////////
	// The bus keeps answering in halt so a stalled master never hangs.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{aw_held_r, w_held_r, bvalid_r, rvalid_r, wstrb_r} <= 5'h00;
			{waddr_r, wbyte_r, rdata_r} <= 24'h00_0000;
			{bresp_r, rresp_r} <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held_r <= 1'b1;
				waddr_r   <= awaddr;
			end
			if (wvalid && wready) begin
				w_held_r <= 1'b1;
				wbyte_r  <= wdata[7:0];
				wstrb_r  <= wstrb[0];
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= (|wr_sel) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bready) begin
				bvalid_r <= 1'b0;
			end
			if (rd_fire) begin
				rvalid_r <= 1'b1;
				rdata_r  <= rd_mux;
				rresp_r  <= (|rd_sel) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic     tx_busy, tx_done_raw, txd, rx_word_raw, rx_noise, rx_frame, rx_idle_raw;
	logic [8:0] rx_data;
	tx_kind_e tx_kind;

	// Compare with >= so a smaller divisor written mid-count applies at once, not after a wrap.
	wire logic baud_tick = run && (baud_cnt_r >= baud_r);
	wire logic txon_rise = tx_on && !txon_q_r;
	wire logic brk_rise  = brk && !brk_q_r;
	wire logic brk_go    = brk || brk_pend_r;
	wire logic tx_start  = run && tx_on && !tx_busy && (brk_go || pre_pend_r || hold_full_r);
	assign tx_kind = brk_go ? KIND_BREAK : pre_pend_r ? KIND_IDLE : KIND_DATA;
	wire logic tx_load   = tx_start && (tx_kind == KIND_DATA);
	wire logic tx_done_p = run && tx_done_raw;

	assign tx_pin    = txd || !tx_on;
	assign tx_pin_oe = tx_on;

	sci_tx u_tx (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (baud_tick),
		.start   (tx_start),
		.kind    (tx_kind),
		.nine    (nine),
		.word    ({ctrl1_r[`C1_TX9], tx_hold_r}),
		.busy    (tx_busy),
		.done    (tx_done_raw),
		.txd     (txd)
	);

	sci_rx u_rx (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.tick      (baud_tick),
		.enable    (rx_on),
		.nine      (nine),
		.rxd       (rx_pin),
		.word_done (rx_word_raw),
		.word      (rx_data),
		.noise     (rx_noise),
		.framing   (rx_frame),
		.idle_det  (rx_idle_raw)
	);

	////////////////////////////////////////////////////////////////////////
	wire logic rx_word   = run && rx_on && rx_word_raw;
	wire logic rx_idle   = run && rx_on && rx_idle_raw;
	wire logic addr_mark = nine ? rx_data[8] : rx_data[7];
	wire logic wake_am   = mute && wake_m && rx_word && addr_mark;
	wire logic wake_il   = mute && !wake_m && rx_idle;
	wire logic live_word = rx_word && (!mute || wake_am);
	wire logic rx_accept = live_word && !status_r[`ST_RXF];
	wire logic ovr_set   = live_word && status_r[`ST_RXF];
	wire logic idle_set  = rx_idle && !mute && idle_arm_r;

	// Framing and noise only rise with a transfer, so overrun hides them.
	assign set_v = {tx_load, tx_done_p, rx_accept, idle_set, ovr_set,
			rx_accept && rx_noise, rx_accept && rx_frame, 1'b0};
	assign txrx_clr_v = (dr_wr ? `TX_MASK : 8'h00) | (dr_rd ? `RX_MASK : 8'h00);
	assign clr_v = (arm_r & txrx_clr_v) | (rx_on ? 8'h00 : `RX_MASK);
	// Set beats clear, so an event in the clearing cycle survives.
	assign status_nxt = (status_r & ~clr_v) | set_v;
	assign arm_nxt = st_acc ? status_r : (arm_r & ~txrx_clr_v);
	assign ctrl2_nxt = wr_c2 ? wbyte_r :
			ctrl2_r & ~({7'h00, wake_am || wake_il} << `C2_MUTE);

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_r   <= `STATUS_RST;
			ctrl2_r    <= `CTRL2_RST;
			ctrl1_r    <= `CTRL1_RST;
			baud_r     <= `BAUD_RST;
			{arm_r, baud_cnt_r, tx_hold_r, rx_hold_r} <= 32'h0000_0000;
			{hold_full_r, pre_pend_r, brk_pend_r, txon_q_r, brk_q_r} <= 5'h00;
			idle_arm_r <= 1'b1;
		end else if (run) begin
			status_r   <= status_nxt;
			arm_r      <= arm_nxt;
			ctrl2_r    <= ctrl2_nxt;
			baud_cnt_r <= baud_tick ? 8'h00 : baud_cnt_r + 8'h01;
			txon_q_r   <= tx_on;
			brk_q_r    <= brk;
			if (wr_c1)
				ctrl1_r <= (ctrl1_r & ~`C1_WMASK) | (wbyte_r & `C1_WMASK);
			if (rx_accept)
				ctrl1_r[`C1_RX9] <= nine && rx_data[8];
			if (wr_en && wr_sel[2])
				baud_r <= wbyte_r;
			if (dr_wr)
				tx_hold_r <= wbyte_r;
			if (rx_accept)
				rx_hold_r <= rx_data[7:0];
			hold_full_r <= dr_wr || (hold_full_r && !tx_load && !(txon_q_r && !tx_on));
			pre_pend_r  <= txon_rise || (pre_pend_r && !(tx_start && tx_kind == KIND_IDLE));
			brk_pend_r  <= (brk_pend_r || brk_rise) && !(tx_start && tx_kind == KIND_BREAK);
			if (rx_accept)
				idle_arm_r <= 1'b1;
			else if (idle_set)
				idle_arm_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	wire logic tx_irq = (status_r[`ST_TX_BUFFER_EMPTY] && tx_empty_irq_en) || (status_r[`ST_TC] && tx_done_irq_en);
	wire logic rx_irq = !mute && ((rx_irq_en && (status_r[`ST_RXF] || status_r[`ST_OR])) ||
			(line_quiet_irq_en && status_r[`ST_IDLE]));
	assign irq       = !cpu_irq_mask && (tx_irq || rx_irq);
	assign wait_exit = irq;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_mute_quiet;
		mute && !wake_am && !wr_c2 |=> !$rose(status_r[`ST_RXF]) && !$rose(status_r[`ST_OR]);
	endproperty
	a_mute_quiet: assert property (p_mute_quiet)
		else $error("muted receiver raised a flag");

	property p_addr_wake;
		wake_am && !status_r[`ST_RXF] && !wr_c2 |=> !mute && status_r[`ST_RXF];
	endproperty
	a_addr_wake: assert property (p_addr_wake)
		else $error("address mark did not wake the receiver");

	property p_idle_wake;
		wake_il && !wr_c2 |=> !mute && !$rose(status_r[`ST_IDLE]);
	endproperty
	a_idle_wake: assert property (p_idle_wake)
		else $error("idle wake misbehaved");

	property p_irq_mask;
		irq == (!cpu_irq_mask && ((status_r[`ST_TX_BUFFER_EMPTY] && tx_empty_irq_en) || (status_r[`ST_TC] && tx_done_irq_en) ||
			(!mute && rx_irq_en && (status_r[`ST_RXF] || status_r[`ST_OR])) ||
			(!mute && line_quiet_irq_en && status_r[`ST_IDLE])));
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("interrupt raised while masked");

	property p_wait_exit;
		status_r[`ST_TX_BUFFER_EMPTY] && tx_empty_irq_en && !cpu_irq_mask |-> irq && wait_exit;
	endproperty
	a_wait_exit: assert property (p_wait_exit)
		else $error("enabled event did not end wait");

	property p_tx_buffer_empty_set;
		tx_load |=> status_r[`ST_TX_BUFFER_EMPTY] && tx_busy;
	endproperty
	a_tx_buffer_empty_set: assert property (p_tx_buffer_empty_set)
		else $error("buffer empty flag not set on load");

	property p_tc_set;
		tx_done_p |=> status_r[`ST_TC];
	endproperty
	a_tc_set: assert property (p_tc_set)
		else $error("transmit done flag not set");

	property p_rxf_clear;
		dr_rd && arm_r[`ST_RXF] && !rx_accept |=> !status_r[`ST_RXF];
	endproperty
	a_rxf_clear: assert property (p_rxf_clear)
		else $error("receive full flag not cleared");

	property p_overrun;
		ovr_set |=> status_r[`ST_OR] && $stable(rx_hold_r) && !$rose(status_r[`ST_FE]);
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun handling wrong");

	property p_rx_off;
		!rx_on && run |=> (status_r & `RX_MASK) == 8'h00;
	endproperty
	a_rx_off: assert property (p_rx_off)
		else $error("receive flags survive receiver off");

	property p_reset_val;
		$past(aresetn) == 1'b0 |-> status_r == `STATUS_RST && ctrl2_r == `CTRL2_RST;
	endproperty
	a_reset_val: assert property (p_reset_val)
		else $error("wrong reset value");

	property p_halt_freeze;
		halt_mode |=> $stable(status_r) && $stable(ctrl2_r) && $stable(ctrl1_r);
	endproperty
	a_halt_freeze: assert property (p_halt_freeze)
		else $error("register changed in halt");

	property p_noise_pair;
		$rose(status_r[`ST_NF]) |-> $rose(status_r[`ST_RXF]);
	endproperty
	a_noise_pair: assert property (p_noise_pair)
		else $error("noise flag rose without a new word");

	property p_frame_pair;
		$rose(status_r[`ST_FE]) |-> $rose(status_r[`ST_RXF]);
	endproperty
	a_frame_pair: assert property (p_frame_pair)
		else $error("framing flag rose without a new word");

	c_addr_wake: cover property (wake_am);
	c_idle_wake: cover property (wake_il);
	c_overrun: cover property (ovr_set);
	c_break: cover property (tx_start && tx_kind == KIND_BREAK);
	c_nine_word: cover property (rx_accept && nine);
endmodule

// File: design/sci_params.svh
`ifndef SCI_PARAMS_SVH
`define SCI_PARAMS_SVH
`define OFF_STATUS  8'h00
`define OFF_DATA    8'h04
`define OFF_BAUD    8'h08
`define OFF_CTRL1   8'h0C
`define OFF_CTRL2   8'h10
`define STATUS_RST  8'hC0
`define CTRL1_RST   8'h00
`define CTRL2_RST   8'h00
`define BAUD_RST    8'h81
`define ST_TX_BUFFER_EMPTY     7
`define ST_TC       6
`define ST_RXF      5
`define ST_IDLE     4
`define ST_OR       3
`define ST_NF       2
`define ST_FE       1
`define TX_MASK     8'hC0
`define RX_MASK     8'h3E
`define C1_RX9      7
`define C1_TX9      6
`define C1_NINE     4
`define C1_WAKE     3
`define C1_WMASK    8'h58
`define C2_TIE      7
`define C2_TX_DONE_IRQ_EN     6
`define C2_RIE      5
`define C2_LINE_QUIET_IRQ_EN     4
`define C2_TXON     3
`define C2_RXON     2
`define C2_MUTE     1
`define C2_BRK      0
`define OVS_LAST    4'hF
`define SMP_A       4'h7
`define SMP_B       4'h8
`define SMP_C       4'h9
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// File: design/sci_pkg.sv
package sci_pkg;
	typedef enum logic [2:0] {
		KIND_DATA  = 3'b001,
		KIND_IDLE  = 3'b010,
		KIND_BREAK = 3'b100
	} tx_kind_e;
	typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} tx_state_e;
	typedef enum logic [1:0] {RX_HUNT = 2'b01, RX_BITS = 2'b10} rx_state_e;

	// Bits in one frame: start, data and stop.
	function automatic logic [3:0] frame_bits(input logic nine);
		return nine ? 4'hB : 4'hA;
	endfunction
endpackage

// File: design/sci_tx.sv
`include "sci_params.svh"
module sci_tx
	import sci_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       tick,
	input  wire logic       start,
	input  wire tx_kind_e   kind,
	input  wire logic       nine,
	input  wire logic [8:0] word,
	output wire logic       busy,
	output wire logic       done,
	output wire logic       txd
);
	tx_state_e   state_r;
	logic [11:0] shift_r;
	logic [3:0]  tick_cnt_r;
	logic [3:0]  bits_left_r;
	logic        done_r;
	logic        txd_r;
	logic [11:0] load_w;
	logic [3:0]  len_w;

	// A break frame carries one extra bit, the closing mark.
	assign len_w  = (kind == KIND_BREAK) ? frame_bits(nine) + 4'h1 : frame_bits(nine);
	assign load_w = (kind == KIND_IDLE) ? 12'hFFF :
			(kind == KIND_BREAK) ? (nine ? 12'h800 : 12'hC00) :
			nine ? {2'b11, word, 1'b0} : {3'b111, word[7:0], 1'b0};
	assign busy = (state_r == TX_SHIFT);
	assign done = done_r;
	assign txd  = txd_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r     <= TX_IDLE;
			shift_r     <= 12'hFFF;
			tick_cnt_r  <= 4'h0;
			bits_left_r <= 4'h0;
			done_r      <= 1'b0;
			txd_r       <= 1'b1;
		end else begin
			done_r <= 1'b0;
			txd_r  <= busy ? shift_r[0] : 1'b1;
			case (state_r)
				TX_IDLE: if (start) begin
					shift_r     <= load_w;
					bits_left_r <= len_w;
					tick_cnt_r  <= 4'h0;
					state_r     <= TX_SHIFT;
				end
				TX_SHIFT: if (tick) begin
					tick_cnt_r <= tick_cnt_r + 4'h1;
					if (tick_cnt_r == `OVS_LAST) begin
						shift_r     <= {1'b1, shift_r[11:1]};
						bits_left_r <= bits_left_r - 4'h1;
						if (bits_left_r == 4'h1) begin
							state_r <= TX_IDLE;
							done_r  <= 1'b1;
						end
					end
				end
				default: state_r <= TX_IDLE;
			endcase
		end
	end
endmodule

// File: design/sci_rx.sv
`include "sci_params.svh"
module sci_rx
	import sci_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       tick,
	input  wire logic       enable,
	input  wire logic       nine,
	input  wire logic       rxd,
	output wire logic       word_done,
	output wire logic [8:0] word,
	output wire logic       noise,
	output wire logic       framing,
	output wire logic       idle_det
);
	rx_state_e   state_r;
	logic [3:0]  cnt_r;
	logic [3:0]  idx_r;
	logic [10:0] shift_r;
	logic        smp_a_r, smp_b_r, noise_acc_r, done_r, idle_r, idle_taken_r;
	logic [7:0]  quiet_r;
	logic [8:0]  word_r;
	logic        noise_r, frame_r;
	wire logic   maj_w  = (smp_a_r & smp_b_r) | (smp_a_r & rxd) | (smp_b_r & rxd);
	wire logic   dis_w  = !((smp_a_r == smp_b_r) && (smp_b_r == rxd));
	wire logic   last_w = (idx_r == frame_bits(nine) - 4'h1);
	wire logic [7:0] quiet_lim_w = {frame_bits(nine), 4'h0};

	assign word_done = done_r;
	assign word      = word_r;
	assign noise     = noise_r;
	assign framing   = frame_r;
	assign idle_det  = idle_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= RX_HUNT;
			{cnt_r, idx_r, quiet_r} <= 16'h0000;
			shift_r <= 11'h000;
			{smp_a_r, smp_b_r, noise_acc_r, done_r, idle_r, idle_taken_r} <= 6'h00;
			word_r  <= 9'h000;
			{noise_r, frame_r} <= 2'b00;
		end else begin
			done_r <= 1'b0;
			idle_r <= 1'b0;
			if (!enable) begin
				state_r      <= RX_HUNT;
				quiet_r      <= 8'h00;
				idle_taken_r <= 1'b0;
			end else if (tick) begin
				case (state_r)
					RX_HUNT: if (!rxd) begin
						state_r      <= RX_BITS;
						cnt_r        <= 4'h1;
						idx_r        <= 4'h0;
						noise_acc_r  <= 1'b0;
						quiet_r      <= 8'h00;
						idle_taken_r <= 1'b0;
					end else if (quiet_r == quiet_lim_w) begin
						idle_r       <= !idle_taken_r;
						idle_taken_r <= 1'b1;
					end else begin
						quiet_r <= quiet_r + 8'h01;
					end
					RX_BITS: begin
						cnt_r <= cnt_r + 4'h1;
						if (cnt_r == `SMP_A) smp_a_r <= rxd;
						if (cnt_r == `SMP_B) smp_b_r <= rxd;
						if (cnt_r == `SMP_C) begin
							idx_r <= idx_r + 4'h1;
							if (idx_r == 4'h0 && maj_w) begin
								// A start bit that reads high was a glitch.
								state_r <= RX_HUNT;
							end else begin
								shift_r     <= {maj_w, shift_r[10:1]};
								noise_acc_r <= noise_acc_r | dis_w;
							end
							if (last_w) begin
								state_r <= RX_HUNT;
								done_r  <= 1'b1;
								word_r  <= nine ? shift_r[10:2] : {1'b0, shift_r[10:3]};
								noise_r <= noise_acc_r | dis_w;
								frame_r <= !maj_w;
							end
						end
					end
					default: state_r <= RX_HUNT;
				endcase
			end
		end
	end
endmodule

// File: dv/serial_node.sv
module serial_node
(
	input  wire logic aclk,
	input  wire logic tx_pin,
	output var  logic rx_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT_CYC = 16;

	initial rx_pin = 1'b1;

	////////////////////////////////////////////////////////////////////////////////
	// The frame ends in idle-high bits, so back-to-back calls never drive the line twice at once.
	task automatic send(input logic [8:0] w, input logic nine, input logic stop);
		logic [11:0] f;
		f = nine ? {1'b1, stop, w, 1'b0} : {2'b11, stop, w[7:0], 1'b0};
		for (int i = 0; i < 12; i++) begin
			rx_pin <= f[i];
			repeat (BIT_CYC) @(posedge aclk);
		end
	endtask

	// Eight-bit frame whose first data bit flips for one cycle at its middle sample.
	task automatic send_noisy(input logic [7:0] w);
		logic [11:0] f;
		f = {3'b111, w, 1'b0};
		for (int i = 0; i < 12; i++) begin
			rx_pin <= f[i];
			repeat (BIT_CYC / 2) @(posedge aclk);
			if (i == 1)
				rx_pin <= ~f[i];
			@(posedge aclk);
			rx_pin <= f[i];
			repeat (BIT_CYC / 2 - 1) @(posedge aclk);
		end
	endtask

	// Samples mid-bit; a frame that never starts leaves the stop bit unknown.
	task automatic recv(input logic nine, output logic [8:0] w, output logic stop);
		int n;
		n = 0;
		w = 9'h000;
		stop = 1'bx;
		while (tx_pin !== 1'b0 && n < 4000) begin
			@(posedge aclk);
			n++;
		end
		repeat (BIT_CYC / 2) @(posedge aclk);
		for (int i = 0; i < 9; i++) begin
			if (i < 8 || nine) begin
				repeat (BIT_CYC) @(posedge aclk);
				w[i] = tx_pin;
			end
		end
		repeat (BIT_CYC) @(posedge aclk);
		if (n < 4000)
			stop = tx_pin;
	endtask
endmodule

// File: dv/sci_status_control_mute_wakeup_tb.sv
`include "sci_params.svh"
module sci_status_control_mute_wakeup_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] A_ST = `OFF_STATUS;
	localparam logic [7:0] A_DT = `OFF_DATA;
	localparam logic [7:0] A_C1 = `OFF_CTRL1;
	localparam logic [7:0] A_C2 = `OFF_CTRL2;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        halt_mode, cpu_irq_mask, tx_pin, tx_pin_oe, irq, wait_exit, stp;
	wire logic   rx_line;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rv;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	logic [8:0]  w, d;
	int          err_count, checks;

	sci_status_control_mute_wakeup dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .halt_mode(halt_mode), .cpu_irq_mask(cpu_irq_mask), .rx_pin(rx_line),
		.tx_pin(tx_pin), .tx_pin_oe(tx_pin_oe), .irq(irq), .wait_exit(wait_exit));
	serial_node node (.aclk(aclk), .tx_pin(tx_pin), .rx_pin(rx_line));

	always #12.5 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Handshakes are judged at the falling edge, where the combinational readies have
	// settled; the release then lands just after the rising edge that took the item.
	task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h00_0000, v};
		wstrb <= 4'hf;
		wvalid <= 1'b1;
		bready <= 1'b1;
		repeat (64) begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tb) begin
				bready <= 1'b0;
				break;
			end
		end
		if (tb !== 1'b1)
			err_count++;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		logic ta, tb;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		repeat (64) begin
			@(negedge aclk);
			ta = arvalid & arready;
			tb = rvalid;
			v = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
			if (tb) begin
				rready <= 1'b0;
				break;
			end
		end
		if (tb !== 1'b1)
			err_count++;
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		rd(a, rv, rs);
		chk(what, rv & m, e);
	endtask

	// Shared request: any enabled flag, overrun riding on the receive enable, unless masked.
	function automatic logic exp_irq(input logic [7:0] st, input logic [7:0] c2, input logic m);
		return !m & ((|(st[7:4] & c2[7:4])) | (c2[5] & st[3]));
	endfunction

	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, halt_mode} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		cpu_irq_mask = 1'b1;
		err_count = 0;
		checks = 0;
		void'($urandom(32'h686a_f27d));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rchk("status", A_ST, 32'hff, 32'hc0);
		rchk("control_two", A_C2, 32'hffff_ffff, 32'h0);
		rd(8'h14, rv, rs);
		chk("unmapped", 32'(rs), 32'(`RESP_SLVERR));
		wr(A_DT + 8'h04, 8'h00, rs);
		chk("write resp", 32'(rs), 32'(`RESP_OKAY));
		$display("test reset done");
		wr(A_C2, 8'h24, rs);
		d = {1'b0, 8'($urandom)};
		node.send(d, 1'b0, 1'b1);
		chk("irq masked", 32'(irq), 32'(exp_irq(8'he0, 8'h24, 1'b1)));
		cpu_irq_mask <= 1'b0;
		rchk("rx flag", A_ST, 32'h2e, 32'h20);
		chk("irq rx", 32'({irq, wait_exit}), 32'h3);
		rchk("rx data", A_DT, 32'hff, 32'(d[7:0]));
		rchk("rx cleared", A_ST, 32'h2e, 32'h0);
		node.send(d, 1'b0, 1'b1);
		node.send(~d, 1'b0, 1'b0);
		rchk("overrun", A_ST, 32'h2e, 32'h28);
		chk("irq overrun", 32'(irq), 32'(exp_irq(8'he8, 8'h24, 1'b0)));
		rchk("kept word", A_DT, 32'hff, 32'(d[7:0]));
		rchk("errors cleared", A_ST, 32'h2e, 32'h0);
		node.send_noisy(d[7:0]);
		rchk("noise", A_ST, 32'h2e, 32'h24);
		rchk("noisy word", A_DT, 32'hff, 32'(d[7:0]));
		node.send(d, 1'b0, 1'b0);
		rchk("framing", A_ST, 32'h2e, 32'h22);
		wr(A_C2, 8'h20, rs);
		rchk("rx off", A_ST, 32'h3e, 32'h0);
		$display("test receive done");
		wr(A_C1, 8'h08, rs);
		wr(A_C2, 8'h26, rs);
		d = {2'b00, 7'($urandom)};
		node.send(d, 1'b0, 1'b1);
		rchk("muted", A_ST, 32'h3e, 32'h0);
		chk("muted irq", 32'(irq), 32'h0);
		d[7] = 1'b1;
		node.send(d, 1'b0, 1'b1);
		rchk("mark wake", A_C2, 32'hff, 32'h24);
		rchk("mark flag", A_ST, 32'h2e, 32'h20);
		rchk("mark word", A_DT, 32'hff, 32'(d[7:0]));
		wr(A_C2, 8'h00, rs);
		wr(A_C1, 8'h00, rs);
		wr(A_C2, 8'h16, rs);
		repeat (200) @(posedge aclk);
		rchk("idle wake", A_C2, 32'hff, 32'h14);
		rchk("no quiet", A_ST, 32'h10, 32'h0);
		node.send({1'b0, 8'($urandom)}, 1'b0, 1'b1);
		repeat (200) @(posedge aclk);
		rchk("quiet", A_ST, 32'h30, 32'h30);
		chk("quiet irq", 32'(irq), 32'(exp_irq(8'h30, 8'h16, 1'b0)));
		wr(A_C2, 8'h00, rs);
		wr(A_C1, 8'h10, rs);
		wr(A_C2, 8'h04, rs);
		d = 9'($urandom);
		node.send(d, 1'b1, 1'b1);
		rchk("ninth bit", A_C1, 32'h80, 32'({d[8], 7'h00}));
		rchk("nine word", A_DT, 32'hff, 32'(d[7:0]));
		wr(A_C2, 8'h00, rs);
		$display("test mute done");
		wr(A_C2, 8'h88, rs);
		chk("pin owned", 32'(tx_pin_oe), 32'h1);
		repeat (200) @(posedge aclk);
		for (int k = 0; k < 2; k++) begin
			d = 9'($urandom);
			wr(A_C1, {1'b0, d[8], 1'b0, k[0], 4'h0}, rs);
			fork
				begin
					rd(A_ST, rv, rs);
					wr(A_DT, d[7:0], rs);
					rd(A_ST, rv, rs);
				end
				node.recv(k[0], w, stp);
			join
			chk("tx word", 32'(w), k ? 32'(d) : 32'(d[7:0]));
			chk("tx stop", 32'(stp), 32'h1);
			chk("tx flags", rv & 32'hc0, 32'h80);
			repeat (24) @(posedge aclk);
			rchk("tx done", A_ST, 32'hc0, 32'hc0);
			chk("tx irq", 32'(irq), 32'(exp_irq(8'hc0, 8'h88, 1'b0)));
		end
		fork
			begin
				wr(A_C2, 8'h09, rs);
				wr(A_C2, 8'h08, rs);
			end
			node.recv(1'b0, w, stp);
		join
		chk("break word", 32'(w), 32'h0);
		chk("break stop", 32'(stp), 32'h0);
		repeat (200) @(posedge aclk);
		$display("test transmit done");
		halt_mode <= 1'b1;
		wr(A_C2, 8'h00, rs);
		rchk("halt frozen", A_C2, 32'hff, 32'h08);
		halt_mode <= 1'b0;
		wr(A_C2, 8'h00, rs);
		chk("pin released", 32'({tx_pin_oe, tx_pin}), 32'h1);
		$display("test halt done");
		summarize();
	end
endmodule
